//--- src/sbm_menu.sv
// Purpose: Single push-button menu: aim, setup and learn functions
// Assumes: Button and trigger inputs are clean and synchronous
// Notes:   Image engine reports setup and learn success by pulses
`timescale 1ns/1ps

// Contract
// - Blink all LEDs one second at startup
// - Release on aim LED: aim, laser on
// - Press during aim ends it, laser off
// - Release on setup LED: setup, LED blinks
// - Setup success: store, stop blink, three beeps
// - Setup five second timeout: long low beep
// - Release on learn LED: learn, LED blinks
// - Learn success: store, spot on, three beeps
// - Learn three minute timeout: long low beep
// - Only one learned code, new replaces old
// - Press cancels any function after delay
// - Learn rejects postal, pharma, MSI, 2of5 codes
// - Triggered modes start reading on trigger
module sbm_menu #(
   parameter logic [sbm_pkg::TMR_W-1:0]   STARTUP_CYC    = sbm_pkg::TMR_W'(sbm_pkg::STARTUP_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   STEP_CYC       = sbm_pkg::TMR_W'(sbm_pkg::STEP_CYC),
   parameter logic [sbm_pkg::BLINK_W-1:0] BLINK_CYC      = sbm_pkg::BLINK_W'(sbm_pkg::BLINK_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   CANCEL_CYC     = sbm_pkg::TMR_W'(sbm_pkg::CANCEL_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   SETUP_TO_CYC   = sbm_pkg::TMR_W'(sbm_pkg::SETUP_TO_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   LEARN_TO_CYC   = sbm_pkg::TMR_W'(sbm_pkg::LEARN_TO_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   SHORT_BEEP_CYC = sbm_pkg::TMR_W'(sbm_pkg::SHORT_BEEP_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   BEEP_GAP_CYC   = sbm_pkg::TMR_W'(sbm_pkg::BEEP_GAP_CYC),
   parameter logic [sbm_pkg::TMR_W-1:0]   LONG_BEEP_CYC  = sbm_pkg::TMR_W'(sbm_pkg::LONG_BEEP_CYC)
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  button_in,
   input  wire logic                  trigger_input_a,
   input  wire logic                  trigger_input_b,
   input  wire logic                  mode_triggered_in,
   input  wire logic                  setup_ok_in,
   input  wire logic                  learn_ok_in,
   input  wire sbm_pkg::sbm_sym_type  learn_sym_in,
   output sbm_pkg::sbm_led_type       leds_out,
   output logic                       laser_out,
   output logic                       good_spot_out,
   output sbm_pkg::sbm_beep_type      beep_out,
   output logic                       setup_run_out,
   output logic                       learn_run_out,
   output logic                       store_setup_out,
   output logic                       store_learn_out,
   output sbm_pkg::sbm_sym_type       learned_code_out,
   output logic                       read_start_out
);

   // ****************************************************
   // Declarations
   // ****************************************************
   sbm_pkg::sbm_main_type       st_reg;      // Whole block state
   sbm_pkg::sbm_main_type       st_next;     // Next state
   logic                        m_start;     // Load main timer
   logic [sbm_pkg::TMR_W-1:0]   m_val;       // Main timer load value
   logic                        m_exp;       // Main timer expired
   logic                        b_start;     // Load beep timer
   logic [sbm_pkg::TMR_W-1:0]   b_val;       // Beep timer load value
   logic                        b_exp;       // Beep timer expired
   logic                        press;       // Button went down
   logic                        trig;        // Trigger pair level
   logic                        excluded;    // Learned class not allowed
   logic                        beep_req;    // Start a beep pattern
   logic                        beep_hi;     // Pattern pitch
   logic [1:0]                  beep_n;      // Pattern beep count

   // ****************************************************
   // Timers
   // ****************************************************
   sbm_timer u_main_tmr (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .start_in    (m_start),
      .value_in    (m_val),
      .expired_out (m_exp)
   );

   sbm_timer u_beep_tmr (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .start_in    (b_start),
      .value_in    (b_val),
      .expired_out (b_exp)
   );

   // ****************************************************
   // Menu sequencing
   // ****************************************************
   always_comb begin
      st_next = st_reg;
      m_start = 1'b0;
      m_val = '0;
      b_start = 1'b0;
      b_val = '0;
      beep_req = 1'b0;
      beep_hi = 1'b0;
      beep_n = 2'h0;
      press = button_in & ~st_reg.btn_prev;
      // Pair is polarity insensitive, either sense triggers
      trig = trigger_input_a ^ trigger_input_b;
      excluded = (learn_sym_in == sbm_pkg::SYM_POSTAL) || (learn_sym_in == sbm_pkg::SYM_PHARMA)
         || (learn_sym_in == sbm_pkg::SYM_MSI) || (learn_sym_in == sbm_pkg::SYM_STD_2OF5)
         || (learn_sym_in == sbm_pkg::SYM_MAT_2OF5);
      st_next.btn_prev = button_in;
      st_next.trig_prev = trig;
      st_next.store_setup = 1'b0;
      st_next.store_learn = 1'b0;
      st_next.read_start = 1'b0;
      // Free running blink phase
      if (st_reg.blink_cnt >= BLINK_CYC - sbm_pkg::BLINK_W'(1)) begin
         st_next.blink_cnt = '0;
         st_next.blink_ph = ~st_reg.blink_ph;
      end else begin
         st_next.blink_cnt = st_reg.blink_cnt + sbm_pkg::BLINK_W'(1);
      end
      case (st_reg.state)
         sbm_pkg::S_BOOT: begin
            // Arm the startup blink once, leave when it runs out
            if (!st_reg.booted) begin
               st_next.booted = 1'b1;
               m_start = 1'b1;
               m_val = STARTUP_CYC;
            end else if (m_exp) begin
               st_next.state = sbm_pkg::S_IDLE;
            end
         end
         sbm_pkg::S_IDLE: begin
            if (press) begin
               st_next.state = sbm_pkg::S_HOLD;
               st_next.sel = sbm_pkg::SEL_NONE;
               m_start = 1'b1;
               m_val = STEP_CYC;
            end else if (mode_triggered_in && trig && !st_reg.trig_prev) begin
               st_next.read_start = 1'b1;
            end
         end
         sbm_pkg::S_HOLD: begin
            if (!button_in) begin
               // Release picks the indicator lit now
               case (st_reg.sel)
                  sbm_pkg::SEL_AIM: begin
                     st_next.state = sbm_pkg::S_AIM;
                     st_next.laser = 1'b1;
                  end
                  sbm_pkg::SEL_SETUP: begin
                     st_next.state = sbm_pkg::S_SETUP;
                     m_start = 1'b1;
                     m_val = SETUP_TO_CYC;
                  end
                  sbm_pkg::SEL_LEARN: begin
                     st_next.state = sbm_pkg::S_LEARN;
                     st_next.spot = 1'b0;
                     m_start = 1'b1;
                     m_val = LEARN_TO_CYC;
                  end
                  default: begin
                     st_next.state = sbm_pkg::S_IDLE;
                  end
               endcase
            end else if (m_exp) begin
               // Step to the next indicator, wrap after learn
               st_next.sel = (st_reg.sel == sbm_pkg::SEL_LEARN) ? sbm_pkg::SEL_AIM :
                  sbm_pkg::sbm_sel_type'(st_reg.sel + 2'h1);
               m_start = 1'b1;
               m_val = STEP_CYC;
            end
         end
         sbm_pkg::S_AIM, sbm_pkg::S_SETUP, sbm_pkg::S_LEARN: begin
            if (press) begin
               // One press cancels whatever runs
               st_next.state = sbm_pkg::S_CANCEL;
               m_start = 1'b1;
               m_val = CANCEL_CYC;
            end else if (st_reg.state == sbm_pkg::S_SETUP && setup_ok_in) begin
               st_next.state = sbm_pkg::S_IDLE;
               st_next.store_setup = 1'b1;
               beep_req = 1'b1;
               beep_hi = 1'b1;
               beep_n = sbm_pkg::BEEPS_GOOD;
            end else if (st_reg.state == sbm_pkg::S_LEARN && learn_ok_in && !excluded) begin
               st_next.state = sbm_pkg::S_IDLE;
               st_next.store_learn = 1'b1;
               st_next.learned = learn_sym_in;
               st_next.spot = 1'b1;
               beep_req = 1'b1;
               beep_hi = 1'b1;
               beep_n = sbm_pkg::BEEPS_GOOD;
            end else if (st_reg.state != sbm_pkg::S_AIM && m_exp) begin
               // Give up without storing
               st_next.state = sbm_pkg::S_IDLE;
               beep_req = 1'b1;
               beep_n = sbm_pkg::BEEPS_FAIL;
            end
         end
         sbm_pkg::S_CANCEL: begin
            if (m_exp) begin
               st_next.state = sbm_pkg::S_IDLE;
               st_next.laser = 1'b0;
            end
         end
         default: begin
            st_next.state = sbm_pkg::S_BOOT;
         end
      endcase
      st_next.setup_run = (st_next.state == sbm_pkg::S_SETUP);
      st_next.learn_run = (st_next.state == sbm_pkg::S_LEARN);
      // Beep pattern sequencer
      if (beep_req) begin
         st_next.beep_left = beep_n;
         st_next.beep.on = 1'b1;
         st_next.beep.high = beep_hi;
         b_start = 1'b1;
         b_val = beep_hi ? SHORT_BEEP_CYC : LONG_BEEP_CYC;
      end else if (b_exp) begin
         if (st_reg.beep.on) begin
            st_next.beep.on = 1'b0;
            st_next.beep_left = st_reg.beep_left - 2'h1;
            if (st_reg.beep_left > 2'h1) begin
               b_start = 1'b1;
               b_val = BEEP_GAP_CYC;
            end
         end else if (st_reg.beep_left != 2'h0) begin
            st_next.beep.on = 1'b1;
            b_start = 1'b1;
            b_val = SHORT_BEEP_CYC;
         end
      end
      // Indicators follow the coming state
      st_next.leds = '0;
      case (st_next.state)
         sbm_pkg::S_BOOT: begin
            st_next.leds = {3{st_next.blink_ph}};
         end
         sbm_pkg::S_HOLD: begin
            st_next.leds.aim = (st_next.sel == sbm_pkg::SEL_AIM);
            st_next.leds.setup = (st_next.sel == sbm_pkg::SEL_SETUP);
            st_next.leds.learn = (st_next.sel == sbm_pkg::SEL_LEARN);
         end
         sbm_pkg::S_AIM: begin
            st_next.leds.aim = 1'b1;
         end
         sbm_pkg::S_SETUP: begin
            st_next.leds.setup = st_next.blink_ph;
         end
         sbm_pkg::S_LEARN: begin
            st_next.leds.learn = st_next.blink_ph;
         end
         default: begin
            st_next.leds = '0;
         end
      endcase
   end

   // Register the record
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg <= '{state: sbm_pkg::S_BOOT, sel: sbm_pkg::SEL_NONE,
                     learned: sbm_pkg::SYM_GENERIC, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign leds_out         = st_reg.leds;
   assign laser_out        = st_reg.laser;
   assign good_spot_out    = st_reg.spot;
   assign beep_out         = st_reg.beep;
   assign setup_run_out    = st_reg.setup_run;
   assign learn_run_out    = st_reg.learn_run;
   assign store_setup_out  = st_reg.store_setup;
   assign store_learn_out  = st_reg.store_learn;
   assign learned_code_out = st_reg.learned;
   assign read_start_out   = st_reg.read_start;

   // ****************************************************
   // Assertions
   // ****************************************************
   a_boot_leds_equal: assert property (@(posedge clk_in) disable iff (rst_in)
      st_reg.state == sbm_pkg::S_BOOT |-> (leds_out == '0 || leds_out == '1))
      else $error("startup LEDs not blinking together");

   a_aim_laser_on: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_HOLD && !button_in && st_reg.sel == sbm_pkg::SEL_AIM)
      |=> laser_out && leds_out.aim)
      else $error("aim release did not light laser");

   a_aim_press_end: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_AIM && press) |=> st_reg.state == sbm_pkg::S_CANCEL
      ##[1:300] !laser_out)
      else $error("aim press did not end aim");

   a_setup_success: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_SETUP && !press && setup_ok_in)
      |=> store_setup_out && beep_out.high && st_reg.beep_left == 2'h3 && !leds_out.setup)
      else $error("setup success not reported");

   a_setup_timeout: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_SETUP && !press && !setup_ok_in && m_exp)
      |=> !store_setup_out && beep_out.on && !beep_out.high && !setup_run_out)
      else $error("setup timeout not reported");

   a_learn_spot: assert property (@(posedge clk_in) disable iff (rst_in)
      store_learn_out |-> good_spot_out && beep_out.high && !learn_run_out)
      else $error("learn store without spot");

   a_learn_replace: assert property (@(posedge clk_in) disable iff (rst_in)
      store_learn_out |-> learned_code_out == $past(learn_sym_in))
      else $error("learned code not replaced");

   a_learn_exclude: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_LEARN && learn_ok_in && excluded) |=> !store_learn_out)
      else $error("excluded symbology was learned");

   a_trigger_read: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg.state == sbm_pkg::S_IDLE && !press && mode_triggered_in && trig
       && !st_reg.trig_prev) |=> read_start_out)
      else $error("trigger did not start reading");

   a_cancel_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(st_reg.state == sbm_pkg::S_CANCEL) |-> !store_setup_out && !store_learn_out)
      else $error("cancel stored parameters");

endmodule // sbm_menu

//--- src/sbm_pkg.sv
// Purpose: Shared constants and types for the single button setup menu
// Assumes: 200 MHz clock, all inputs synchronous to it
// Notes:   Times are kept in milliseconds, cycle counts derive from them
package sbm_pkg;

   // ****************************************************
   // Clock and times
   // ****************************************************
   localparam longint CLK_HZ        = 64'd200_000_000;     // Core clock rate
   localparam longint MS_CYC        = CLK_HZ / 64'd1000;   // Cycles per millisecond
   localparam longint STARTUP_MS    = 64'd1000;            // All-LED blink at startup
   localparam longint STEP_MS       = 64'd1000;            // Indicator step while held
   localparam longint BLINK_MS      = 64'd250;             // Half period of blinking
   localparam longint CANCEL_MS     = 64'd200;             // Delay before cancel acts
   localparam longint SETUP_TO_MS   = 64'd5000;            // Setup give-up time
   localparam longint LEARN_TO_MS   = 64'd180000;          // Learn give-up time
   localparam longint SHORT_BEEP_MS = 64'd100;             // Short high beep
   localparam longint BEEP_GAP_MS   = 64'd100;             // Silence between beeps
   localparam longint LONG_BEEP_MS  = 64'd1000;            // Long low beep

   localparam longint STARTUP_CYC    = STARTUP_MS * MS_CYC;
   localparam longint STEP_CYC       = STEP_MS * MS_CYC;
   localparam longint BLINK_CYC      = BLINK_MS * MS_CYC;
   localparam longint CANCEL_CYC     = CANCEL_MS * MS_CYC;
   localparam longint SETUP_TO_CYC   = SETUP_TO_MS * MS_CYC;
   localparam longint LEARN_TO_CYC   = LEARN_TO_MS * MS_CYC;
   localparam longint SHORT_BEEP_CYC = SHORT_BEEP_MS * MS_CYC;
   localparam longint BEEP_GAP_CYC   = BEEP_GAP_MS * MS_CYC;
   localparam longint LONG_BEEP_CYC  = LONG_BEEP_MS * MS_CYC;

   // ****************************************************
   // Widths and counts
   // ****************************************************
   localparam int         TMR_W       = 36;     // Holds three minutes of cycles
   localparam int         BLINK_W     = 26;     // Holds one blink half period
   localparam logic [1:0] BEEPS_GOOD  = 2'h3;   // Beeps on success
   localparam logic [1:0] BEEPS_FAIL  = 2'h1;   // Beeps on timeout

   // ****************************************************
   // Enumerations
   // ****************************************************
   typedef enum logic [6:0] {
      S_BOOT   = 7'h01,
      S_IDLE   = 7'h02,
      S_HOLD   = 7'h04,
      S_AIM    = 7'h08,
      S_SETUP  = 7'h10,
      S_LEARN  = 7'h20,
      S_CANCEL = 7'h40
   } sbm_state_type;

   typedef enum logic [1:0] {
      SEL_NONE  = 2'h0,
      SEL_AIM   = 2'h1,
      SEL_SETUP = 2'h2,
      SEL_LEARN = 2'h3
   } sbm_sel_type;

   // Symbology class reported by the decoder
   typedef enum logic [2:0] {
      SYM_GENERIC  = 3'h0,
      SYM_POSTAL   = 3'h1,
      SYM_PHARMA   = 3'h2,
      SYM_MSI      = 3'h3,
      SYM_STD_2OF5 = 3'h4,
      SYM_MAT_2OF5 = 3'h5,
      SYM_LINEAR   = 3'h6,
      SYM_MATRIX   = 3'h7
   } sbm_sym_type;

   // ****************************************************
   // Carriers and state records
   // ****************************************************
   typedef struct packed {
      logic aim;
      logic setup;
      logic learn;
   } sbm_led_type;

   typedef struct packed {
      logic on;       // Beeper sounding
      logic high;     // High pitch when set, low otherwise
   } sbm_beep_type;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             expired;
   } sbm_tmr_type;

   typedef struct packed {
      sbm_state_type      state;
      sbm_sel_type        sel;
      logic               booted;
      logic               btn_prev;
      logic               trig_prev;
      logic [BLINK_W-1:0] blink_cnt;
      logic               blink_ph;
      logic [1:0]         beep_left;
      sbm_beep_type       beep;
      sbm_led_type        leds;
      logic               laser;
      logic               spot;
      logic               store_setup;
      logic               store_learn;
      sbm_sym_type        learned;
      logic               read_start;
      logic               setup_run;
      logic               learn_run;
   } sbm_main_type;

endpackage

//--- src/sbm_timer.sv
// Purpose: One-shot down counter giving a single expiry pulse
// Assumes: start_in reloads at any time and wins over counting
// Notes:   A cleared counter stays silent until loaded again
`timescale 1ns/1ps

module sbm_timer (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     start_in,
   input  wire logic [sbm_pkg::TMR_W-1:0] value_in,
   output logic                          expired_out
);

   sbm_pkg::sbm_tmr_type tmr_reg;    // Count and expiry flag
   sbm_pkg::sbm_tmr_type tmr_next;   // Next value

   // ****************************************************
   // Count down, pulse on the last step
   // ****************************************************
   always_comb begin
      tmr_next = tmr_reg;
      tmr_next.expired = 1'b0;
      if (start_in) begin
         tmr_next.cnt = value_in;
      end else if (tmr_reg.cnt != '0) begin
         tmr_next.cnt = tmr_reg.cnt - sbm_pkg::TMR_W'(1);
         tmr_next.expired = (tmr_reg.cnt == sbm_pkg::TMR_W'(1));
      end
   end

   // Register the record
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign expired_out = tmr_reg.expired;

endmodule // sbm_timer

//--- dv/sbm_operator.sv
// Purpose: Operator model pressing the single menu button
// Assumes: Button level is sampled on the rising clock edge
// Notes:   Holds until the wanted indicator lights, as a person would
`timescale 1ns/1ps

module sbm_operator (
   input  wire logic                 clk_in,
   input  wire sbm_pkg::sbm_led_type leds_in,
   output logic                      button_out
);
   // ****************************************************
   // Button actions
   // ****************************************************
   initial button_out = 1'b0;   // Released at start

   // Hold until the wanted indicator lights, then let go
   task automatic pick(input int idx, output logic ok);
      int n;
      n = 0;
      @(posedge clk_in) button_out <= 1'b1;
      while (leds_in[idx] !== 1'b1 && n < 200) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      ok = leds_in[idx];
      @(posedge clk_in) button_out <= 1'b0;
   endtask

   // One short press, used to leave a function
   task automatic tap();
      @(posedge clk_in) button_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      button_out <= 1'b0;
   endtask
endmodule // sbm_operator

//--- dv/test_single_button_setup_menu.sv
// Purpose: Self-checking bench for the single button setup menu
// Assumes: Shortened timing parameters, operator model on the button
// Notes:   Setup and learn scenario tasks drive engine inputs, every scenario task judges outputs
`timescale 1ns/1ps

module test_single_button_setup_menu;
   // ****************************************************
   // Shortened times and bench signals
   // ****************************************************
   localparam int ST = 40, STEP = 20, BLK = 4, CAN = 5, STO = 100, LTO = 200;
   logic                  clk_in, rst_in, button_in, trigger_input_a, trigger_input_b;
   logic                  mode_triggered_in, setup_ok_in, learn_ok_in;
   sbm_pkg::sbm_sym_type  learn_sym_in, learned_code_out;
   sbm_pkg::sbm_led_type  leds_out, leds_prev;
   sbm_pkg::sbm_beep_type beep_out;
   logic                  laser_out, good_spot_out, setup_run_out, learn_run_out;
   logic                  store_setup_out, store_learn_out, read_start_out, pitch, on_prev;
   int                    failures, comparisons, cycles, beeps, stores, learns, reads, changes;

   sbm_menu #(.STARTUP_CYC(ST), .STEP_CYC(STEP), .BLINK_CYC(BLK), .CANCEL_CYC(CAN),
      .SETUP_TO_CYC(STO), .LEARN_TO_CYC(LTO), .SHORT_BEEP_CYC(3), .BEEP_GAP_CYC(3),
      .LONG_BEEP_CYC(10)) i_dut (.clk_in, .rst_in, .button_in, .trigger_input_a,
      .trigger_input_b, .mode_triggered_in, .setup_ok_in, .learn_ok_in, .learn_sym_in,
      .leds_out, .laser_out, .good_spot_out, .beep_out, .setup_run_out, .learn_run_out,
      .store_setup_out, .store_learn_out, .learned_code_out, .read_start_out);
   sbm_operator i_op (.clk_in, .leds_in(leds_out), .button_out(button_in));

   // ****************************************************
   // Clock, event counting and hang guard
   // ****************************************************
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // Counts beeps, pulses and LED changes seen at each edge
   always @(posedge clk_in) begin
      cycles++;
      if (beep_out.on && !on_prev) beeps++;
      if (beep_out.on) pitch = beep_out.high;
      if (store_setup_out) stores++;
      if (store_learn_out) learns++;
      if (read_start_out) reads++;
      if (leds_out != leds_prev) changes++;
      on_prev = beep_out.on;
      leds_prev = leds_out;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Clears the event counts, then lets n edges pass
   task automatic watch(input int n);
      {beeps, stores, learns, reads, changes} = '0;
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic pulse(input logic lrn, input sbm_pkg::sbm_sym_type sym);
      @(posedge clk_in);
      learn_sym_in <= sym;
      learn_ok_in <= lrn;
      setup_ok_in <= !lrn;
      @(posedge clk_in);
      learn_ok_in <= 1'b0;
      setup_ok_in <= 1'b0;
   endtask

   task automatic enter(input int idx);
      logic ok;
      i_op.pick(idx, ok);
      check("indicator lit", 1, ok);
      watch(2);
   endtask

   task automatic trig(input logic a, b, m, input int exp);
      @(posedge clk_in);
      trigger_input_a <= a;
      trigger_input_b <= b;
      mode_triggered_in <= m;
      watch(4);
      check("read starts", exp, reads);
   endtask

   task automatic finish_ok(input int lrn, input int exp_store);
      check("stores", exp_store, lrn ? learns : stores);
      check("beep count", exp_store ? 3 : 1, beeps);
      check("beep pitch", exp_store, pitch);
      check("run ended", 0, lrn ? learn_run_out : setup_run_out);
      check("blink ended", 0, lrn ? leds_out.learn : leds_out.setup);
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_startup();
      repeat (ST - 4) begin
         @(posedge clk_in);
         #1;
         check("leds together", {3{leds_out.aim}}, leds_out);
      end
      check("startup blink", 1, changes >= 6);
      watch(10);
      check("leds after startup", 0, leds_out);
   endtask

   task automatic t_aim();
      enter(2);
      check("laser on", 1, laser_out);
      i_op.tap();
      watch(1);
      check("laser in delay", 1, laser_out);
      watch(CAN + 3);
      check("laser off", 0, laser_out);
   endtask

   task automatic t_setup(input logic succeed);
      enter(1);
      check("setup running", 1, setup_run_out);
      watch(12);
      check("setup blinking", 1, changes >= 2);
      if (succeed) begin
         pulse(1'b0, sbm_pkg::SYM_GENERIC);
      end else begin
         watch(STO - 24);
         check("setup waits", 1, setup_run_out);
      end
      watch(40);
      finish_ok(0, succeed);
   endtask

   task automatic t_learn(input logic succeed, input sbm_pkg::sbm_sym_type sym);
      enter(0);
      check("learn running", 1, learn_run_out);
      check("spot cleared", 0, good_spot_out);
      for (int s = 1; s <= 5; s++) begin
         pulse(1'b1, sbm_pkg::sbm_sym_type'(s));
         watch(3);
         check("excluded class", 0, learns);
      end
      watch(12);
      check("learn blinking", 1, changes >= 2);
      if (succeed) begin
         pulse(1'b1, sym);
      end else begin
         watch(LTO - 50);
      end
      watch(40);
      finish_ok(1, succeed);
      check("good spot", succeed, good_spot_out);
      check("stored code", sym, learned_code_out);
   endtask

   task automatic t_cancel(input int idx);
      enter(idx);
      i_op.tap();
      watch(CAN + 6);
      check("cancelled", 0, idx == 1 ? setup_run_out : learn_run_out);
      check("nothing stored", 0, stores + learns);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {rst_in, trigger_input_a, trigger_input_b, mode_triggered_in} = 4'h8;
      {setup_ok_in, learn_ok_in} = 2'h0;
      learn_sym_in = sbm_pkg::SYM_GENERIC;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      t_startup();
      trig(1, 0, 0, 0);
      trig(0, 0, 1, 0);
      trig(0, 1, 1, 1);
      trig(1, 1, 1, 0);
      t_aim();
      t_setup(1'b1);
      t_cancel(1);
      t_setup(1'b0);
      t_learn(1'b1, sbm_pkg::SYM_LINEAR);
      t_learn(1'b1, sbm_pkg::SYM_MATRIX);
      t_cancel(0);
      t_learn(1'b0, sbm_pkg::SYM_MATRIX);
      wrap_up();
   end
endmodule // test_single_button_setup_menu
